/* File: verilog/dcu_device.sv */
`timescale 1ns/1ps
module dcu_buf
  import dcu_pkg::*;
#(
  parameter int unsigned WIDTH = CHAR_W,
  parameter int unsigned DEPTH = BUF_DEPTH
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_reset,
  // Fill side
  input  wire logic [WIDTH-1:0] i_in_data,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  // Drain side
  output logic [WIDTH-1:0]      o_out_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  // Pointer wrap and full count assume at least two entries
  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
    $error("dcu_buf: DEPTH must be at least 2 and WIDTH at least 1");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0]    cnt_q, cnt_d;
  logic             push, pop;

  assign o_in_ready  = (cnt_q != CNT_FULL);
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rd_q];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = i_in_data;
      wr_d        = (wr_q == PTR_LAST) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == PTR_LAST) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule // dcu_buf

module dcu_device
  import dcu_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_reset,
  // Chain link
  dcu_link_if.dev                link,
  // Configuration
  input  wire logic [1:0]        i_serial_path_config,
  input  wire logic [ADDR_W-1:0] i_device_address,
  // Alert source
  input  wire logic              i_alert,
  // Status
  input  wire logic              i_flag_clear,
  output logic                   o_target_write_reject_flag,
  // Command indications
  output logic                   o_up_cmd_valid,
  output logic                   o_up_cmd_write,
  output logic                   o_down_read_valid
);
  function automatic logic [OP_W-1:0] cmd_op(input logic [CHAR_W-1:0] c);
    return c[OP_LSB +: OP_W];
  endfunction

  function automatic logic cmd_for_me(input logic [CHAR_W-1:0] c,
                                      input logic [ADDR_W-1:0] a);
    return c[ADDR_W-1:0] == a;
  endfunction

  logic lb, alert_mode, dual;
  assign lb         = (i_serial_path_config == CFG_INT_LOOP);
  assign alert_mode = (i_serial_path_config == CFG_ALERT);
  assign dual       = (i_serial_path_config == CFG_DUAL);

  // Upward path
  logic [CHAR_W-1:0] upb_data;
  logic              upb_valid, upb_ready;

  dcu_buf #(.WIDTH(CHAR_W), .DEPTH(BUF_DEPTH)) u_up_buf (
    .i_clock     (i_clock),
    .i_reset     (i_reset),
    .i_in_data   (link.lo_rx_data),
    .i_in_valid  (link.lo_rx_valid),
    .o_in_ready  (link.lo_rx_ready),
    .o_out_data  (upb_data),
    .o_out_valid (upb_valid),
    .i_out_ready (upb_ready)
  );

  assign link.up_tx_data  = upb_data;
  assign link.up_tx_valid = upb_valid && !lb;

  // Downward source: external upper receive or internal loop
  logic [CHAR_W-1:0] src_data;
  logic              src_valid, src_ready;
  logic              dnb_in_ready, dnb_valid;

  assign src_data  = lb ? upb_data : link.up_rx_data;
  assign src_valid = lb ? upb_valid : link.up_rx_valid;
  assign upb_ready = lb ? src_ready : link.up_tx_ready;
  // Alert mode discards returning data instead of stalling the chain
  assign src_ready = alert_mode ? 1'b1 : dnb_in_ready;
  // Loopback drops whatever arrives on the pins, echo included
  assign link.up_rx_ready = lb ? 1'b1 : src_ready;

  dcu_buf #(.WIDTH(CHAR_W), .DEPTH(BUF_DEPTH)) u_dn_buf (
    .i_clock     (i_clock),
    .i_reset     (i_reset),
    .i_in_data   (src_data),
    .i_in_valid  (src_valid && !alert_mode),
    .o_in_ready  (dnb_in_ready),
    .o_out_data  (link.lo_tx_data),
    .o_out_valid (dnb_valid),
    .i_out_ready (link.lo_tx_ready && !alert_mode)
  );

  // Pass-through in every mode but alert
  assign link.lo_tx_valid = dnb_valid && !alert_mode;

  // Alert pair driven from flops
  logic alert_p_q, alert_p_d, alert_n_q, alert_n_d;

  always_comb begin
    alert_p_d = alert_mode && i_alert;
    alert_n_d = alert_mode && !i_alert;
  end

  assign link.alert_p = alert_p_q;
  assign link.alert_n = alert_n_q;

  // Frame trackers: index 0 upward, 1 downward
  logic [1:0]        acc;
  logic [CHAR_W-1:0] chr [2];
  dcu_frame_e        fr_q [2];
  dcu_frame_e        fr_d [2];
  logic [1:0]        at_cmd;

  assign acc[0] = link.lo_rx_valid && link.lo_rx_ready;
  assign acc[1] = src_valid && src_ready && dual;
  assign chr[0] = link.lo_rx_data;
  assign chr[1] = src_data;

  for (genvar p = 0; p < 2; p++) begin : g_frame
    assign at_cmd[p] = acc[p] && (fr_q[p] == FR_CMD);

    always_comb begin
      fr_d[p] = fr_q[p];
      if (acc[p]) begin
        case (fr_q[p])
          FR_IDLE: fr_d[p] = (chr[p] == CH_PREAMBLE) ? FR_CMD : FR_IDLE;
          FR_CMD:  fr_d[p] = FR_BODY;
          FR_BODY: fr_d[p] = (chr[p] == CH_STOP) ? FR_IDLE : FR_BODY;
          default: fr_d[p] = FR_IDLE;
        endcase
      end
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
        fr_q[p] <= FR_IDLE;
      end else begin
        fr_q[p] <= fr_d[p];
      end
    end
  end

  // Command indications and sticky flag
  logic up_cmd_q, up_cmd_d, up_wr_q, up_wr_d, dn_rd_q, dn_rd_d;
  logic flag_q, flag_d, flag_set;

  always_comb begin
    up_cmd_d = at_cmd[0] && cmd_for_me(chr[0], i_device_address)
               && (cmd_op(chr[0]) == OP_READ || cmd_op(chr[0]) == OP_WRITE);
    up_wr_d  = at_cmd[0] && cmd_op(chr[0]) == OP_WRITE;
    dn_rd_d  = at_cmd[1] && cmd_op(chr[1]) == OP_READ
               && cmd_for_me(chr[1], i_device_address);
    // Write on the target path is forwarded untouched, only flagged
    flag_set = at_cmd[1] && cmd_op(chr[1]) == OP_WRITE;
    flag_d   = flag_set || (flag_q && !i_flag_clear);
  end

  assign o_up_cmd_valid             = up_cmd_q;
  assign o_up_cmd_write             = up_wr_q;
  assign o_down_read_valid          = dn_rd_q;
  assign o_target_write_reject_flag = flag_q;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      up_cmd_q  <= 1'b0;
      up_wr_q   <= 1'b0;
      dn_rd_q   <= 1'b0;
      flag_q    <= 1'b0;
      alert_p_q <= 1'b0;
      alert_n_q <= 1'b0;
    end else begin
      up_cmd_q  <= up_cmd_d;
      up_wr_q   <= up_wr_d;
      dn_rd_q   <= dn_rd_d;
      flag_q    <= flag_d;
      alert_p_q <= alert_p_d;
      alert_n_q <= alert_n_d;
    end
  end
endmodule // dcu_device

/* File: common/dcu_pkg.sv */
package dcu_pkg;
  localparam int unsigned CHAR_W      = 8;
  localparam int unsigned ADDR_W      = 5;
  localparam int unsigned OP_W        = 3;
  localparam int unsigned OP_LSB      = 5;
  localparam int unsigned MAX_DEVICES = 32;
  localparam int unsigned BUF_DEPTH   = 2;

  localparam logic [1:0] CFG_EXT_LOOP = 2'h0;
  localparam logic [1:0] CFG_INT_LOOP = 2'h1;
  localparam logic [1:0] CFG_ALERT    = 2'h2;
  localparam logic [1:0] CFG_DUAL     = 2'h3;
  localparam logic [1:0] CFG_RESET    = CFG_EXT_LOOP;

  localparam logic [CHAR_W-1:0] CH_PREAMBLE = 8'hf0;
  localparam logic [CHAR_W-1:0] CH_STOP     = 8'h0f;

  localparam logic [OP_W-1:0] OP_READ  = 3'h1;
  localparam logic [OP_W-1:0] OP_WRITE = 3'h2;

  typedef enum logic [1:0] {
    FR_IDLE,
    FR_CMD,
    FR_BODY
  } dcu_frame_e;
endpackage

/* File: common/dcu_link_if.sv */
`timescale 1ns/1ps
interface dcu_link_if;
  import dcu_pkg::*;
  // Lower port, into device (upward traffic)
  logic [CHAR_W-1:0] lo_rx_data;
  logic              lo_rx_valid;
  logic              lo_rx_ready;
  // Lower port, out of device (returning traffic)
  logic [CHAR_W-1:0] lo_tx_data;
  logic              lo_tx_valid;
  logic              lo_tx_ready;
  // Upper port, out of device
  logic [CHAR_W-1:0] up_tx_data;
  logic              up_tx_valid;
  logic              up_tx_ready;
  // Upper port, into device
  logic [CHAR_W-1:0] up_rx_data;
  logic              up_rx_valid;
  logic              up_rx_ready;
  // Differential alert on lower transmit
  logic              alert_p;
  logic              alert_n;

  modport dev (
    input  lo_rx_data, lo_rx_valid, output lo_rx_ready,
    output lo_tx_data, lo_tx_valid, input  lo_tx_ready,
    output up_tx_data, up_tx_valid, input  up_tx_ready,
    input  up_rx_data, up_rx_valid, output up_rx_ready,
    output alert_p, alert_n
  );
  modport far (
    output lo_rx_data, lo_rx_valid, input  lo_rx_ready,
    input  lo_tx_data, lo_tx_valid, output lo_tx_ready,
    input  up_tx_data, up_tx_valid, output up_tx_ready,
    output up_rx_data, up_rx_valid, input  up_rx_ready,
    input  alert_p, alert_n
  );
endinterface

/* File: verilog/dcu_chain_end.sv */
`timescale 1ns/1ps
module dcu_chain_end
  import dcu_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_reset,
  // Chain link
  dcu_link_if.far                link,
  // Host transmit
  input  wire logic [CHAR_W-1:0] i_tx_data,
  input  wire logic              i_tx_valid,
  output logic                   o_tx_ready,
  // Host receive
  output logic [CHAR_W-1:0]      o_rx_data,
  output logic                   o_rx_valid,
  input  wire logic              i_rx_ready,
  input  wire logic              i_rx_flush,
  // Upper side
  input  wire logic              i_loop_cable
);
  logic [CHAR_W-1:0] tx_q, tx_d, rx_q, rx_d, cab_q, cab_d;
  logic              txv_q, txv_d, rxv_q, rxv_d, cabv_q, cabv_d;

  // Host alone starts traffic
  assign o_tx_ready       = !txv_q || link.lo_rx_ready;
  assign link.lo_rx_data  = tx_q;
  assign link.lo_rx_valid = txv_q;

  assign link.lo_tx_ready = !rxv_q || i_rx_ready;
  assign o_rx_data        = rx_q;
  assign o_rx_valid       = rxv_q;

  // Loop cable above the top device
  assign link.up_tx_ready = !i_loop_cable || !cabv_q || link.up_rx_ready;
  assign link.up_rx_data  = cab_q;
  assign link.up_rx_valid = cabv_q && i_loop_cable;

  always_comb begin
    tx_d  = tx_q;
    txv_d = txv_q;
    if (o_tx_ready) begin
      tx_d  = i_tx_data;
      txv_d = i_tx_valid;
    end
    rx_d  = rx_q;
    rxv_d = rxv_q;
    if (link.lo_tx_ready) begin
      rx_d  = link.lo_tx_data;
      rxv_d = link.lo_tx_valid;
    end
    // Flush discards held and arriving words alike
    if (i_rx_flush) begin
      rxv_d = 1'b0;
    end
    cab_d  = cab_q;
    cabv_d = cabv_q && i_loop_cable;
    if (link.up_tx_ready) begin
      cab_d  = link.up_tx_data;
      cabv_d = link.up_tx_valid && i_loop_cable;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      tx_q   <= '0;
      txv_q  <= 1'b0;
      rx_q   <= '0;
      rxv_q  <= 1'b0;
      cab_q  <= '0;
      cabv_q <= 1'b0;
    end else begin
      tx_q   <= tx_d;
      txv_q  <= txv_d;
      rx_q   <= rx_d;
      rxv_q  <= rxv_d;
      cab_q  <= cab_d;
      cabv_q <= cabv_d;
    end
  end
endmodule // dcu_chain_end

/* File: bench/dcu_link_properties.sv */
`timescale 1ns/1ps
module dcu_link_properties
  import dcu_pkg::*;
(
  // Clock, reset and mode
  input wire logic              i_clock,
  input wire logic              i_reset,
  input wire logic [1:0]        i_serial_path_config,
  input wire logic              i_alert,
  // Link signals
  input wire logic [CHAR_W-1:0] lo_rx_data,
  input wire logic              lo_rx_valid,
  input wire logic              lo_rx_ready,
  input wire logic [CHAR_W-1:0] lo_tx_data,
  input wire logic              lo_tx_valid,
  input wire logic              lo_tx_ready,
  input wire logic [CHAR_W-1:0] up_tx_data,
  input wire logic              up_tx_valid,
  input wire logic              up_tx_ready,
  input wire logic [CHAR_W-1:0] up_rx_data,
  input wire logic              up_rx_valid,
  input wire logic              up_rx_ready,
  input wire logic              alert_p,
  input wire logic              alert_n
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);

  up_forward_a: assert property (
    lo_rx_valid && lo_rx_ready && i_serial_path_config != CFG_INT_LOOP
    ##1 i_serial_path_config != CFG_INT_LOOP |-> up_tx_valid)
    else $error("upward char not forwarded");
  up_hold_a: assert property (
    up_tx_valid && !up_tx_ready ##1 i_serial_path_config != CFG_INT_LOOP
    |-> up_tx_valid && $stable(up_tx_data))
    else $error("upward char dropped under stall");
  loop_quiet_a: assert property (
    i_serial_path_config == CFG_INT_LOOP |-> !up_tx_valid)
    else $error("upper transmit active in loopback");
  loop_ignore_a: assert property (
    i_serial_path_config == CFG_INT_LOOP |-> up_rx_ready)
    else $error("upper receive not ignored in loopback");
  down_forward_a: assert property (
    up_rx_valid && up_rx_ready
    && (i_serial_path_config == CFG_EXT_LOOP || i_serial_path_config == CFG_DUAL)
    ##1 (i_serial_path_config == CFG_EXT_LOOP || i_serial_path_config == CFG_DUAL)
    |-> lo_tx_valid)
    else $error("returning char not forwarded");
  down_hold_a: assert property (
    lo_tx_valid && !lo_tx_ready ##1 i_serial_path_config != CFG_ALERT
    |-> lo_tx_valid && $stable(lo_tx_data))
    else $error("returning char dropped under stall");
  alert_drive_a: assert property (
    i_serial_path_config == CFG_ALERT
    |=> alert_p == $past(i_alert) && alert_n == !$past(i_alert))
    else $error("alert pair wrong");
  alert_gate_a: assert property (
    i_serial_path_config == CFG_ALERT |-> !lo_tx_valid)
    else $error("data returned in alert mode");
  alert_idle_a: assert property (
    i_serial_path_config != CFG_ALERT |=> !alert_p && !alert_n)
    else $error("alert pair active outside alert mode");
endmodule // dcu_link_properties

/* File: bench/daisy_chain_uart_path_config_bench.sv */
`timescale 1ns/1ps
module daisy_chain_uart_path_config_bench;
  import dcu_pkg::*;
  logic        i_clock    = 1'b0;
  logic        i_reset    = 1'b1;
  logic [1:0]  cfg        = CFG_EXT_LOOP;
  logic        alert      = 1'b0;
  logic        flag_clear = 1'b0;
  logic        flag;
  logic        up_cmd_valid;
  logic        up_cmd_write;
  logic        down_read;
  logic [7:0]  tx_data    = 8'h00;
  logic        tx_valid   = 1'b0;
  logic        tx_ready;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic        rx_ready   = 1'b1;
  logic        rx_flush   = 1'b0;
  logic        loop_cable = 1'b1;
  logic        full_seen  = 1'b0;
  logic [7:0]  rxq[$];
  int          up_cmds, up_writes, down_reads, mismatches, checks_done;

  always #5 i_clock = ~i_clock;

  dcu_link_if link ();
  dcu_device dcu_device_inst (.i_clock(i_clock), .i_reset(i_reset), .link(link),
    .i_serial_path_config(cfg), .i_device_address(5'h03), .i_alert(alert),
    .i_flag_clear(flag_clear), .o_target_write_reject_flag(flag),
    .o_up_cmd_valid(up_cmd_valid), .o_up_cmd_write(up_cmd_write),
    .o_down_read_valid(down_read));
  dcu_chain_end dcu_chain_end_inst (.i_clock(i_clock), .i_reset(i_reset), .link(link),
    .i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
    .o_rx_data(rx_data), .o_rx_valid(rx_valid), .i_rx_ready(rx_ready),
    .i_rx_flush(rx_flush), .i_loop_cable(loop_cable));
  dcu_link_properties dcu_link_properties_inst (.i_clock(i_clock), .i_reset(i_reset),
    .i_serial_path_config(cfg), .i_alert(alert),
    .lo_rx_data(link.lo_rx_data), .lo_rx_valid(link.lo_rx_valid),
    .lo_rx_ready(link.lo_rx_ready), .lo_tx_data(link.lo_tx_data),
    .lo_tx_valid(link.lo_tx_valid), .lo_tx_ready(link.lo_tx_ready),
    .up_tx_data(link.up_tx_data), .up_tx_valid(link.up_tx_valid),
    .up_tx_ready(link.up_tx_ready), .up_rx_data(link.up_rx_data),
    .up_rx_valid(link.up_rx_valid), .up_rx_ready(link.up_rx_ready),
    .alert_p(link.alert_p), .alert_n(link.alert_n));

  // Collect returned chars and command pulses
  always @(posedge i_clock) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_data);
    if (up_cmd_valid === 1'b1) up_cmds++;
    if (up_cmd_valid === 1'b1 && up_cmd_write === 1'b1) up_writes++;
    if (down_read === 1'b1) down_reads++;
    if (link.lo_rx_ready === 1'b0) full_seen = 1'b1;
  end

  task check(input logic [31:0] seen, input logic [31:0] want, input string what);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("MISMATCH at %0t: %s seen %0h want %0h", $time, what, seen, want);
    end
  endtask

  task end_test(input string name);
    $display("Test %s done", name);
    up_cmds = 0;
    up_writes = 0;
    down_reads = 0;
  endtask

  task send(input logic [7:0] b);
    int n;
    tx_data <= b;
    tx_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (tx_ready !== 1'b1 && n < 200);
  endtask

  // Back-to-back frames; valid drops only after the last char
  task frames(input logic [7:0] cmd, input int n);
    for (int i = 0; i < n; i++) begin
      send(CH_PREAMBLE);
      send(cmd);
      send(CH_STOP);
    end
    tx_valid <= 1'b0;
  endtask

  task wait_rx(input int n);
    int k;
    k = 0;
    while (rxq.size() < n && k < 80) begin
      @(posedge i_clock);
      k++;
    end
    repeat (4) @(posedge i_clock);
  endtask

  task expect_frames(input logic [7:0] cmd, input int n);
    check(rxq.size(), 3 * n, "returned count");
    for (int i = 0; i < rxq.size() && i < 3 * n; i++)
      check(rxq[i], (i % 3 == 0) ? CH_PREAMBLE : (i % 3 == 1) ? cmd : CH_STOP, "char");
    rxq.delete();
  endtask

  task set_mode(input logic [1:0] m);
    cfg <= m;
    repeat (3) @(posedge i_clock);
  endtask

  task wrap_up;
    $display("Counts: %0d checks, %0d mismatches", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #200us;
    mismatches++;
    wrap_up;
  end

  initial begin
    repeat (5) @(posedge i_clock);
    i_reset <= 1'b0;
    @(posedge i_clock);
    frames(8'h23, 1);
    wait_rx(3);
    expect_frames(8'h23, 1);
    check(up_cmds, 1, "addressed read");
    frames(8'h24, 1);
    wait_rx(3);
    expect_frames(8'h24, 1);
    check(up_cmds, 1, "unaddressed read");
    frames(8'h43, 1);
    wait_rx(3);
    expect_frames(8'h43, 1);
    check(up_writes, 1, "addressed write");
    check(down_reads, 0, "return decoded");
    check(flag, 1'b0, "flag in mode 00");
    end_test("ext_loop");
    rx_ready <= 1'b0;
    frames(8'h24, 2);
    repeat (20) @(posedge i_clock);
    check(full_seen, 1'b1, "buffer refused");
    check(rxq.size(), 0, "word passed stall");
    rx_ready <= 1'b1;
    wait_rx(6);
    expect_frames(8'h24, 2);
    end_test("stall");
    set_mode(CFG_DUAL);
    frames(8'h23, 1);
    wait_rx(3);
    expect_frames(8'h23, 1);
    check(down_reads, 1, "dual read");
    check(flag, 1'b0, "flag on read");
    frames(8'h43, 1);
    wait_rx(3);
    expect_frames(8'h43, 1);
    check(flag, 1'b1, "flag on write");
    flag_clear <= 1'b1;
    @(posedge i_clock);
    flag_clear <= 1'b0;
    repeat (2) @(posedge i_clock);
    check(flag, 1'b0, "flag cleared");
    end_test("dual");
    rx_flush <= 1'b1;
    @(posedge i_clock);
    rx_flush <= 1'b0;
    // Switch while the preamble sits in the cable stage
    frames(8'h43, 1);
    cfg <= CFG_INT_LOOP;
    wait_rx(3);
    check(rxq.size(), 2, "echo not cut");
    check(rxq[0], 8'h43, "echo tail");
    rx_flush <= 1'b1;
    @(posedge i_clock);
    rx_flush <= 1'b0;
    rxq.delete();
    frames(8'h43, 1);
    wait_rx(3);
    expect_frames(8'h43, 1);
    loop_cable <= 1'b0;
    frames(8'h23, 1);
    wait_rx(3);
    expect_frames(8'h23, 1);
    check(down_reads, 0, "loop return decoded");
    end_test("int_loop");
    set_mode(CFG_ALERT);
    loop_cable <= 1'b1;
    alert <= 1'b1;
    frames(8'h23, 1);
    wait_rx(3);
    check(rxq.size(), 0, "data in alert mode");
    check(link.alert_p, 1'b1, "alert p");
    check(link.alert_n, 1'b0, "alert n");
    alert <= 1'b0;
    repeat (3) @(posedge i_clock);
    end_test("alert");
    wrap_up;
  end
endmodule // daisy_chain_uart_path_config_bench
